// ==== hbe_map.vh ====
// Constants for the multiplexed host bus emulation port
`ifndef HBE_MAP_VH
`define HBE_MAP_VH
// Command opcodes on the command port
`define CMD_NOP 4'h0
`define CMD_READ 4'h1
`define CMD_WRITE 4'h2
`define CMD_AUX_SET 4'h3
`define CMD_AUX_GET 4'h4
`define CMD_WAIT_HIGH 4'h5
`define CMD_WAIT_LOW 4'h6
`define CMD_IRQ_READ 4'h7
// Aux field positions within the low bits of the data byte
`define AUX_ZERO_BIT 0
`define AUX_ONE_BIT 1
// Reset values
`define AUX_OUT_RST 2'h0
`define AUX_OE_RST 2'h0
// Phase lengths in core clock cycles
`define ALE_CYCLES 8'h01
`define SETUP_CYCLES 8'h01
`define STROBE_CYCLES 8'h02
`define HOLD_CYCLES 8'h01
`endif

// ==== hbe_phase_timer.v ====
// Phase duration counter for the bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module hbe_phase_timer #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire reset_n,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire hold,
	output wire done
);
	reg [WIDTH-1:0] count_ff;
	reg [WIDTH-1:0] nxt_count;

	// Reload, hold while stretched, else count down
	always @* begin
		nxt_count = count_ff;
		if (load) begin
			nxt_count = load_value;
		end else if (!hold && count_ff != {WIDTH{1'b0}}) begin
			nxt_count = count_ff - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Counter register
	always @(posedge clk) begin
		if (!reset_n) begin
			count_ff <= {WIDTH{1'b0}};
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Last cycle of a phase, never while stretched; load kept out to avoid a loop
	assign done = (count_ff <= {{(WIDTH-1){1'b0}}, 1'b1}) && !hold;
endmodule
`default_nettype wire

// ==== hbe_aux_pins.v ====
// Two auxiliary I/O pins with drive, read and level detect
`timescale 1ns/10ps
`default_nettype none
`include "hbe_map.vh"
module hbe_aux_pins (
	input wire clk,
	input wire reset_n,
	input wire set_en,
	input wire [1:0] set_value,
	input wire [1:0] set_dir,
	input wire [1:0] pin_in,
	output reg [1:0] pin_out,
	output reg [1:0] pin_oe,
	output reg [1:0] pin_level
);
	// Output latches, directions and registered input levels
	always @(posedge clk) begin
		if (!reset_n) begin
			pin_out <= `AUX_OUT_RST;
			pin_oe <= `AUX_OE_RST;
			pin_level <= 2'h0;
		end else begin
			pin_level <= pin_in;
			if (set_en) begin
				pin_out <= set_value;
				pin_oe <= set_dir;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hbe_bus_master.v ====
// Emulated microcontroller multiplexed bus master, top level
`timescale 1ns/10ps
`default_nettype none
`include "hbe_map.vh"
module hbe_bus_master (
	input wire clk,
	input wire reset_n,
	input wire mode_enable,
	input wire cmd_valid,
	input wire [3:0] cmd_op,
	input wire [15:0] cmd_addr,
	input wire [7:0] cmd_wdata,
	output reg cmd_ready_ff,
	output reg rsp_valid_ff,
	output reg [7:0] rsp_data_ff,
	input wire [7:0] muxed_addr_data_in,
	output reg [7:0] muxed_addr_data_out_ff,
	output reg muxed_addr_data_oe_ff,
	output reg [7:0] addr_high_ff,
	output reg select_n_ff,
	output reg addr_latch_ff,
	output reg read_n_ff,
	output reg write_n_ff,
	input wire wait_extend_in,
	output reg bus_clock_out_ff,
	input wire aux_pin_zero_in,
	output reg aux_pin_zero_out_ff,
	output reg aux_pin_zero_oe_ff,
	input wire aux_pin_one_in,
	output reg aux_pin_one_out_ff,
	output reg aux_pin_one_oe_ff
);
	localparam S_IDLE = 8'h01;
	localparam S_ALE = 8'h02;
	localparam S_SETUP = 8'h04;
	localparam S_STROBE = 8'h08;
	localparam S_HOLD = 8'h10;
	localparam S_WAIT = 8'h20;
	localparam S_DONE = 8'h40;

	reg [7:0] state_ff;
	reg [7:0] nxt_state;
	reg is_write_ff;
	reg wait_high_ff;
	reg read_after_ff;
	reg [15:0] addr_ff;
	reg [7:0] wdata_ff;
	reg [7:0] nxt_load_value;
	reg nxt_load;
	reg aux_set_en;
	wire phase_done;
	wire [1:0] aux_out;
	wire [1:0] aux_oe;
	wire [1:0] aux_level;
	wire stretch;
	wire take_cmd;
	wire [15:0] cycle_addr;
	reg nxt_in_cycle;
	reg nxt_strobe;

	// Ready low only stretches the strobe phase
	assign stretch = (state_ff == S_STROBE) && !wait_extend_in;

	// Accept a command only in idle with the mode on
	assign take_cmd = (state_ff == S_IDLE) && cmd_valid && mode_enable;

	// A cycle started from idle takes its address straight off the command port
	assign cycle_addr = (state_ff == S_IDLE) ? cmd_addr : addr_ff;

	// Select spans latch to hold, a strobe only the strobe phase
	always @* begin
		nxt_in_cycle = 1'b0;
		nxt_strobe = 1'b0;
		case (nxt_state)
			S_ALE, S_SETUP, S_HOLD: begin
				nxt_in_cycle = 1'b1;
			end
			S_STROBE: begin
				nxt_in_cycle = 1'b1;
				nxt_strobe = 1'b1;
			end
			default: begin
				nxt_in_cycle = 1'b0;
			end
		endcase
	end

	hbe_phase_timer #(
		.WIDTH(8)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.load(nxt_load),
		.load_value(nxt_load_value),
		.hold(stretch),
		.done(phase_done)
	);

	hbe_aux_pins u_aux (
		.clk(clk),
		.reset_n(reset_n),
		.set_en(aux_set_en),
		.set_value(cmd_wdata[1:0]),
		.set_dir(cmd_addr[1:0]),
		.pin_in({aux_pin_one_in, aux_pin_zero_in}),
		.pin_out(aux_out),
		.pin_oe(aux_oe),
		.pin_level(aux_level)
	);

	// Aux commands act in idle only
	always @* begin
		aux_set_en = take_cmd && (cmd_op == `CMD_AUX_SET);
	end

	// Sequencer next state and phase loads
	always @* begin
		nxt_state = state_ff;
		nxt_load = 1'b0;
		nxt_load_value = 8'h00;
		case (state_ff)
			S_IDLE: begin
				if (cmd_valid && mode_enable) begin
					case (cmd_op)
						`CMD_READ, `CMD_WRITE: begin
							nxt_state = S_ALE;
							nxt_load = 1'b1;
							nxt_load_value = `ALE_CYCLES;
						end
						`CMD_WAIT_HIGH, `CMD_WAIT_LOW, `CMD_IRQ_READ: begin
							nxt_state = S_WAIT;
						end
						`CMD_AUX_SET, `CMD_AUX_GET: begin
							nxt_state = S_DONE;
						end
						default: begin
							nxt_state = S_IDLE;
						end
					endcase
				end
			end
			S_WAIT: begin
				if (aux_level[`AUX_ONE_BIT] == wait_high_ff) begin
					if (read_after_ff) begin
						nxt_state = S_ALE;
						nxt_load = 1'b1;
						nxt_load_value = `ALE_CYCLES;
					end else begin
						nxt_state = S_DONE;
					end
				end
			end
			S_ALE: begin
				if (phase_done) begin
					nxt_state = S_SETUP;
					nxt_load = 1'b1;
					nxt_load_value = `SETUP_CYCLES;
				end
			end
			S_SETUP: begin
				if (phase_done) begin
					nxt_state = S_STROBE;
					nxt_load = 1'b1;
					nxt_load_value = `STROBE_CYCLES;
				end
			end
			S_STROBE: begin
				if (phase_done) begin
					nxt_state = S_HOLD;
					nxt_load = 1'b1;
					nxt_load_value = `HOLD_CYCLES;
				end
			end
			S_HOLD: begin
				if (phase_done) begin
					nxt_state = S_DONE;
				end
			end
			S_DONE: begin
				nxt_state = S_IDLE;
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
	end

	// Command capture and state register
	always @(posedge clk) begin
		if (!reset_n) begin
			state_ff <= S_IDLE;
			is_write_ff <= 1'b0;
			wait_high_ff <= 1'b0;
			read_after_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wdata_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (take_cmd) begin
				is_write_ff <= (cmd_op == `CMD_WRITE);
				wait_high_ff <= (cmd_op == `CMD_WAIT_HIGH) || (cmd_op == `CMD_IRQ_READ);
				read_after_ff <= (cmd_op == `CMD_IRQ_READ);
				addr_ff <= cmd_addr;
				wdata_ff <= cmd_wdata;
			end
		end
	end

	// Select and latch pulse follow the next phase
	always @(posedge clk) begin
		if (!reset_n) begin
			select_n_ff <= 1'b1;
			addr_latch_ff <= 1'b0;
		end else begin
			addr_latch_ff <= (nxt_state == S_ALE);
			select_n_ff <= !nxt_in_cycle;
		end
	end

	// Strobes only in the strobe phase, picked by direction
	always @(posedge clk) begin
		if (!reset_n) begin
			read_n_ff <= 1'b1;
			write_n_ff <= 1'b1;
		end else begin
			read_n_ff <= !(nxt_strobe && !is_write_ff);
			write_n_ff <= !(nxt_strobe && is_write_ff);
		end
	end

	// High address byte, held after the cycle ends
	always @(posedge clk) begin
		if (!reset_n) begin
			addr_high_ff <= 8'h00;
		end else if (nxt_state == S_ALE) begin
			addr_high_ff <= cycle_addr[15:8];
		end
	end

	// Muxed byte: low address in the latch phase, then write data
	always @(posedge clk) begin
		if (!reset_n) begin
			muxed_addr_data_out_ff <= 8'h00;
			muxed_addr_data_oe_ff <= 1'b0;
		end else if (nxt_state == S_ALE) begin
			muxed_addr_data_out_ff <= cycle_addr[7:0];
			muxed_addr_data_oe_ff <= 1'b1;
		end else if (nxt_in_cycle) begin
			muxed_addr_data_out_ff <= wdata_ff;
			muxed_addr_data_oe_ff <= is_write_ff;
		end else begin
			muxed_addr_data_oe_ff <= 1'b0;
		end
	end

	// End-of-command pulse and idle indication
	always @(posedge clk) begin
		if (!reset_n) begin
			rsp_valid_ff <= 1'b0;
			cmd_ready_ff <= 1'b0;
		end else begin
			rsp_valid_ff <= (state_ff == S_DONE);
			cmd_ready_ff <= (nxt_state == S_IDLE) && mode_enable;
		end
	end

	// Read data captured as the strobe ends, aux levels on request
	always @(posedge clk) begin
		if (!reset_n) begin
			rsp_data_ff <= 8'h00;
		end else if (state_ff == S_STROBE && phase_done && !is_write_ff) begin
			rsp_data_ff <= muxed_addr_data_in;
		end else if (take_cmd && cmd_op == `CMD_AUX_GET) begin
			rsp_data_ff <= {6'h00, aux_level};
		end
	end

	// Master clock out, a toggle at half the core rate while enabled
	always @(posedge clk) begin
		if (!reset_n) begin
			bus_clock_out_ff <= 1'b0;
		end else begin
			bus_clock_out_ff <= mode_enable ? !bus_clock_out_ff : 1'b0;
		end
	end

	// Aux pin drivers mirror the aux latches one cycle later
	always @(posedge clk) begin
		if (!reset_n) begin
			aux_pin_zero_out_ff <= 1'b0;
			aux_pin_zero_oe_ff <= 1'b0;
			aux_pin_one_out_ff <= 1'b0;
			aux_pin_one_oe_ff <= 1'b0;
		end else begin
			aux_pin_zero_out_ff <= aux_out[`AUX_ZERO_BIT];
			aux_pin_zero_oe_ff <= aux_oe[`AUX_ZERO_BIT];
			aux_pin_one_out_ff <= aux_out[`AUX_ONE_BIT];
			aux_pin_one_oe_ff <= aux_oe[`AUX_ONE_BIT];
		end
	end
endmodule
`default_nettype wire

// ==== hbe_checker.sv ====
// Bus protocol checker for the host bus emulation port
`timescale 1ns/10ps
`default_nettype none
module hbe_checker (
	input wire clk,
	input wire reset_n,
	input wire mode_enable,
	input wire cmd_valid,
	input wire [3:0] cmd_op,
	input wire [15:0] cmd_addr,
	input wire [7:0] cmd_wdata,
	input wire cmd_ready_ff,
	input wire rsp_valid_ff,
	input wire [7:0] muxed_addr_data_out_ff,
	input wire muxed_addr_data_oe_ff,
	input wire select_n_ff,
	input wire addr_latch_ff,
	input wire read_n_ff,
	input wire write_n_ff,
	input wire wait_extend_in,
	input wire bus_clock_out_ff,
	input wire aux_pin_zero_out_ff,
	input wire aux_pin_zero_oe_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence take(logic [3:0] op);
		cmd_ready_ff && cmd_valid && cmd_op == op;
	endsequence
	sequence rd_steady;
		take(4'h1) ##1 wait_extend_in [*6];
	endsequence
	idle_select_a: assert property (cmd_ready_ff |-> select_n_ff && read_n_ff && write_n_ff)
		else $error("select or strobe active while idle");
	ale_pulse_a: assert property (take(4'h1) |=> addr_latch_ff && !select_n_ff && muxed_addr_data_oe_ff ##1 !addr_latch_ff)
		else $error("address latch pulse wrong");
	rd_strobe_a: assert property (take(4'h1) |-> ##2 read_n_ff ##1 !read_n_ff && !muxed_addr_data_oe_ff)
		else $error("read strobe not after address phase");
	wr_strobe_a: assert property (take(4'h2) |-> ##2 write_n_ff ##1 !write_n_ff && muxed_addr_data_oe_ff)
		else $error("write strobe not after address phase");
	rd_walk_a: assert property (rd_steady |=> rsp_valid_ff)
		else $error("read answer late");
	wr_setup_a: assert property ($fell(write_n_ff) |-> $past(muxed_addr_data_oe_ff) && muxed_addr_data_oe_ff)
		else $error("write data not set up");
	wr_hold_a: assert property ($rose(write_n_ff) |-> muxed_addr_data_oe_ff && $stable(muxed_addr_data_out_ff))
		else $error("write data not held");
	strobe_stretch_a: assert property (!read_n_ff && !wait_extend_in |=> !read_n_ff)
		else $error("strobe not stretched");
	clk_out_a: assert property ($past(mode_enable) && $past(reset_n) |-> bus_clock_out_ff != $past(bus_clock_out_ff))
		else $error("bus clock not toggling");
	aux_lag_a: assert property (take(4'h3) |-> ##2 aux_pin_zero_oe_ff == $past(cmd_addr[0], 2) &&
		aux_pin_zero_out_ff == $past(cmd_wdata[0], 2))
		else $error("aux pin not updated");
endmodule
bind hbe_bus_master hbe_checker u_hbe_checker (.clk, .reset_n, .mode_enable, .cmd_valid, .cmd_op, .cmd_addr,
	.cmd_wdata, .cmd_ready_ff, .rsp_valid_ff, .muxed_addr_data_out_ff, .muxed_addr_data_oe_ff, .select_n_ff,
	.addr_latch_ff, .read_n_ff, .write_n_ff, .wait_extend_in, .bus_clock_out_ff, .aux_pin_zero_out_ff,
	.aux_pin_zero_oe_ff);
`default_nettype wire

// ==== periph_model.sv ====
// Peripheral model on the multiplexed address/data bus
`timescale 1ns/10ps
`default_nettype none
module periph_model (
	input wire logic clk,
	input wire logic [7:0] bus_out,
	input wire logic [7:0] addr_high,
	input wire logic addr_latch,
	input wire logic read_n,
	input wire logic write_n,
	input wire logic [3:0] stall,
	output logic [7:0] bus_in,
	output logic ready,
	output logic [15:0] wr_word
);
	logic [7:0] lat_ff;
	logic [7:0] drv_ff = 8'h00;
	logic [3:0] cnt_ff;
	// Latch address, count wait states, record writes
	always @(posedge clk) begin
		if (addr_latch)
			lat_ff <= bus_out;
		cnt_ff <= (read_n && write_n) ? stall : cnt_ff - {3'h0, cnt_ff != 4'h0};
		if (!write_n)
			wr_word <= {lat_ff, bus_out};
		if (!read_n)
			drv_ff <= lat_ff ^ addr_high;
	end
	// Ready held low for the first stall cycles of a strobe
	assign ready = (cnt_ff == 4'h0);
	// Released bus shows the inverse of the last value
	assign bus_in = read_n ? ~drv_ff : (lat_ff ^ addr_high);
endmodule
`default_nettype wire

// ==== hbe_bus_master_tb.sv ====
// Self-checking testbench for the host bus emulation port
`timescale 1ns/10ps
`default_nettype none
module hbe_bus_master_tb;
	logic clk, reset_n, mode_enable, cmd_valid, irq, ready, rv, cr, oe, sel, ale, rd, wr, bclk;
	logic [3:0] cmd_op, stall;
	logic [15:0] cmd_addr, wr_word;
	logic [7:0] cmd_wdata, rdat, mux_in, mux_out, ahi;
	logic a0_out, a0_oe, a1_out, a1_oe;
	int miscompares = 0, cmp_count = 0, lat;
	hbe_bus_master u_hbe_bus_master (.clk(clk), .reset_n(reset_n), .mode_enable(mode_enable),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready_ff(cr),
		.rsp_valid_ff(rv), .rsp_data_ff(rdat), .muxed_addr_data_in(mux_in), .muxed_addr_data_out_ff(mux_out),
		.muxed_addr_data_oe_ff(oe), .addr_high_ff(ahi), .select_n_ff(sel), .addr_latch_ff(ale), .read_n_ff(rd),
		.write_n_ff(wr), .wait_extend_in(ready), .bus_clock_out_ff(bclk), .aux_pin_zero_in(a0_oe ? a0_out : 1'b1),
		.aux_pin_zero_out_ff(a0_out), .aux_pin_zero_oe_ff(a0_oe), .aux_pin_one_in(irq),
		.aux_pin_one_out_ff(a1_out), .aux_pin_one_oe_ff(a1_oe));
	periph_model u_periph_model (.clk(clk), .bus_out(mux_out), .addr_high(ahi), .addr_latch(ale), .read_n(rd),
		.write_n(wr), .stall(stall), .bus_in(mux_in), .ready(ready), .wr_word(wr_word));
	task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask
	task cmd(input logic [3:0] op, input logic [15:0] a, input logic [7:0] d);
		lat = 0;
		while (cr !== 1'b1 && lat < 50) begin
			@(posedge clk);
			lat++;
		end
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		lat = 0;
		do begin
			@(posedge clk);
			lat++;
		end while (rv !== 1'b1 && lat < 300);
		chk("answer", 16'h0001, {15'h0, lat < 300});
	endtask
	task aux(input logic [15:0] dir, input logic [7:0] val, input logic [15:0] exp);
		cmd(4'h3, dir, val);
		repeat (3) @(posedge clk);
		cmd(4'h4, 16'h0000, 8'h00);
		chk("aux_get", exp, {8'h00, rdat});
	endtask
	task t_rw;
		cmd(4'h2, 16'hA55A, 8'h3C);
		chk("wr_word", 16'h5A3C, wr_word);
		chk("addr_high", 16'h00A5, {8'h00, ahi});
		cmd(4'h1, 16'h1234, 8'h00);
		chk("rd_len", 16'h0007, lat[15:0]);
		chk("rd_data", 16'h0026, {8'h00, rdat});
		chk("addr_high", 16'h0012, {8'h00, ahi});
		$display("test rw done");
	endtask
	task t_stretch;
		stall <= 4'h3;
		cmd(4'h1, 16'h80F0, 8'h00);
		chk("rd_data", 16'h0070, {8'h00, rdat});
		chk("stretched", 16'h000A, lat[15:0]);
		stall <= 4'h0;
		$display("test stretch done");
	endtask
	task t_aux;
		aux(16'h0001, 8'h01, 16'h0001);
		aux(16'h0001, 8'h00, 16'h0000);
		cmd(4'h3, 16'h0002, 8'h02);
		chk("aux1_drive", 16'h0003, {14'h0, a1_oe, a1_out});
		irq <= 1'b1;
		aux(16'h0000, 8'h00, 16'h0003);
		irq <= 1'b0;
		$display("test aux done");
	endtask
	task t_wait(input logic [3:0] op, input logic lvl);
		fork
			cmd(op, 16'h0F55, 8'h00);
			begin
				repeat (20) @(posedge clk);
				irq <= lvl;
			end
		join
		chk("wait_len", 16'h0001, {15'h0, lat > 15});
		if (op == 4'h7)
			chk("irq_read", 16'h005A, {8'h00, rdat});
		$display("test wait done");
	endtask
	task t_mode;
		mode_enable <= 1'b0;
		repeat (4) @(posedge clk);
		chk("ready_off", 16'h0000, {15'h0, cr});
		chk("bclk_off", 16'h0000, {15'h0, bclk});
		mode_enable <= 1'b1;
		repeat (3) @(posedge clk);
		$display("test mode done");
	endtask
	task results;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Clock at 40 MHz
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Hang guard
	initial begin
		#200000;
		miscompares++;
		results;
	end
	// Main sequence
	initial begin
		{reset_n, cmd_valid, irq, stall, cmd_op, cmd_addr, cmd_wdata} = '0;
		mode_enable = 1'b1;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		t_rw;
		t_stretch;
		t_aux;
		t_wait(4'h5, 1'b1);
		t_wait(4'h6, 1'b0);
		t_wait(4'h7, 1'b1);
		t_mode;
		results;
	end
endmodule
`default_nettype wire
